// ===== ins_ctrl_pkg.sv
// constants and types for the transport-stream packet insertion controller
// What this block does
// - with insertion off, write_index_clear zeroes the write pointer; self-clearing, else ignored.
// - write_index shows next RAM slot written; increments per port write while disabled.
// - with insertion off, read_index_clear zeroes the read pointer; self-clearing, else ignored.
// - read_index shows next slot read; while armed shows slot being fetched.
// - reserved bits of both control registers ignore writes and read zero.
// - fill_ones_trigger fills RAM from write_index onward with all-ones words.
// - writing one to insertion_arm enables packet insertion.
// - hardware clears insertion_arm after a packet insertion completes.
// - setting insertion_arm resets both read and write pointers to zero.
// - when armed, insert packet once stream gap reaches or exceeds gap_offset_time.
// - gap_offset_time: bits 15:12 cycle count, bits 11:0 cycle offset.
// - each insertion_ram_port write while disabled and idle stores its word at the current write pointer.
// - insertion RAM is not cleared by reset; contents undefined until written.
package ins_ctrl_pkg;
	localparam logic [7:0] OFF_RAM_PORT = 8'hA4;
	localparam logic [7:0] OFF_CSR0 = 8'hA8;
	localparam logic [7:0] OFF_CSR1 = 8'hAC;
	localparam int BIT_WR_CLEAR = 30;
	localparam int BIT_WR_IDX_LO = 24;
	localparam int BIT_RD_CLEAR = 22;
	localparam int BIT_RD_IDX_LO = 16;
	localparam int BIT_BUF_SEL_LO = 8;
	localparam int BIT_FILL = 7;
	localparam int BIT_ARM = 6;
	localparam int BIT_LEN_LO = 0;
	localparam int IDX_W = 6;
	localparam int BUF_SEL_W = 3;
	localparam int GAP_W = 16;
	localparam int GAP_CYCLE_OFFSET_W = 12;
	localparam logic [31:0] FILL_WORD = 32'hFFFFFFFF;
	localparam logic [IDX_W-1:0] RST_IDX = 6'h00;
	localparam logic [BUF_SEL_W-1:0] RST_BUF_SEL = 3'h0;
	localparam logic [GAP_W-1:0] RST_GAP = 16'h0000;
	localparam int FIFO_DEPTH = 4;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_FETCH = 4'b0010,
		ST_DRAIN = 4'b0100,
		ST_FILL = 4'b1000
	} ins_state_t;
endpackage

// ===== ins_fifo.sv
// small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module ins_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic push;
	logic pop;

	assign in_ready = (count != CW'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end

	// data storage needs no reset; valid is governed by count
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule // ins_fifo
`default_nettype wire

// ===== ts_packet_insertion_ctrl.sv
// control, status and packet RAM for one transport-stream insertion buffer
`timescale 1ns/1ns
`default_nettype none
module ts_packet_insertion_ctrl #(
	parameter int DEPTH = 64,
	parameter int FIFO_WORDS = ins_ctrl_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic reg_cs,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	input wire logic [15:0] ts_gap_time,
	output logic ins_valid,
	input wire logic ins_ready,
	output logic [31:0] ins_data,
	output logic ins_last,
	output logic [2:0] ins_buffer_select,
	output logic ins_done,
	output logic ins_armed
);
	localparam int IW = ins_ctrl_pkg::IDX_W;
	localparam int FW = 33;

	typedef struct packed {
		ins_ctrl_pkg::ins_state_t st;
		logic arm;
		logic [IW-1:0] wr_idx;
		logic [IW-1:0] rd_idx;
		logic [ins_ctrl_pkg::BUF_SEL_W-1:0] buf_sel;
		logic [IW-1:0] len;
		logic [ins_ctrl_pkg::GAP_W-1:0] gap_thr;
		logic [31:0] rdata;
		logic out_valid;
		logic [31:0] out_data;
		logic out_last;
		logic [ins_ctrl_pkg::BUF_SEL_W-1:0] out_sel;
		logic done;
	} ctrl_state_t;

	ctrl_state_t cur;
	ctrl_state_t nxt;

	logic rst_meta;
	logic rst_n;
	logic [31:0] ram [DEPTH];
	logic ram_we;
	logic [IW-1:0] ram_waddr;
	logic [31:0] ram_wdata;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic [FW-1:0] fifo_in_data;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [FW-1:0] fifo_out_data;
	logic wr_port;
	logic rd_port;
	logic wr_csr0;
	logic wr_csr1;
	logic gap_ok;
	logic fetch_last;

	// reset release through two flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	assign wr_port = reg_cs && reg_wr && (reg_addr == ins_ctrl_pkg::OFF_RAM_PORT);
	assign rd_port = reg_cs && reg_rd && (reg_addr == ins_ctrl_pkg::OFF_RAM_PORT);
	assign wr_csr0 = reg_cs && reg_wr && (reg_addr == ins_ctrl_pkg::OFF_CSR0);
	assign wr_csr1 = reg_cs && reg_wr && (reg_addr == ins_ctrl_pkg::OFF_CSR1);
	// cycle offset never exceeds its range, so the packed value compares as a number
	assign gap_ok = (ts_gap_time >= cur.gap_thr);
	assign fetch_last = (cur.rd_idx == cur.len - 1'b1);

	ins_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_WORDS)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	assign fifo_out_ready = !cur.out_valid || ins_ready;
	assign fifo_in_valid = (cur.st == ins_ctrl_pkg::ST_FETCH);
	assign fifo_in_data = {fetch_last, ram[cur.rd_idx]};

	// packet RAM is left uninitialised by reset
	always_ff @(posedge clk) begin
		if (ram_we) begin
			ram[ram_waddr] <= ram_wdata;
		end
	end

	always_comb begin
		nxt = cur;
		ram_we = 1'b0;
		ram_waddr = cur.wr_idx;
		ram_wdata = reg_wdata;
		nxt.done = 1'b0;
		nxt.rdata = 32'h00000000;

		// register reads; reserved and self-clearing bits read zero
		if (reg_cs && reg_rd) begin
			case (reg_addr)
				ins_ctrl_pkg::OFF_CSR0: begin
					nxt.rdata[ins_ctrl_pkg::BIT_WR_IDX_LO +: IW] = cur.wr_idx;
					nxt.rdata[ins_ctrl_pkg::BIT_RD_IDX_LO +: IW] = cur.rd_idx;
					nxt.rdata[ins_ctrl_pkg::BIT_BUF_SEL_LO +: ins_ctrl_pkg::BUF_SEL_W] =
						cur.buf_sel;
					nxt.rdata[ins_ctrl_pkg::BIT_ARM] = cur.arm;
					nxt.rdata[ins_ctrl_pkg::BIT_LEN_LO +: IW] = cur.len;
				end
				ins_ctrl_pkg::OFF_CSR1: begin
					nxt.rdata[ins_ctrl_pkg::GAP_W-1:0] = cur.gap_thr;
				end
				ins_ctrl_pkg::OFF_RAM_PORT: begin
					if (!cur.arm && cur.st == ins_ctrl_pkg::ST_IDLE) begin
						nxt.rdata = ram[cur.rd_idx];
					end
				end
				default: begin
					nxt.rdata = 32'h00000000;
				end
			endcase
		end

		// port accesses only while disabled and idle
		if (!cur.arm && cur.st == ins_ctrl_pkg::ST_IDLE) begin
			if (wr_port) begin
				ram_we = 1'b1;
				nxt.wr_idx = cur.wr_idx + 1'b1;
			end
			if (rd_port) begin
				nxt.rd_idx = cur.rd_idx + 1'b1;
			end
		end

		if (wr_csr1) begin
			nxt.gap_thr = reg_wdata[ins_ctrl_pkg::GAP_W-1:0];
		end

		// output register stage
		if (fifo_out_ready) begin
			nxt.out_valid = fifo_out_valid;
			nxt.out_data = fifo_out_data[31:0];
			nxt.out_last = fifo_out_data[32];
		end

		case (cur.st)
			ins_ctrl_pkg::ST_IDLE: begin
				if (cur.arm && gap_ok) begin
					if (cur.len == '0) begin
						nxt.arm = 1'b0;
						nxt.done = 1'b1;
					end else begin
						nxt.st = ins_ctrl_pkg::ST_FETCH;
						nxt.rd_idx = ins_ctrl_pkg::RST_IDX;
						nxt.out_sel = cur.buf_sel;
					end
				end
			end
			ins_ctrl_pkg::ST_FETCH: begin
				if (fifo_in_ready) begin
					nxt.rd_idx = cur.rd_idx + 1'b1;
					if (fetch_last) begin
						nxt.st = ins_ctrl_pkg::ST_DRAIN;
					end
				end
			end
			ins_ctrl_pkg::ST_DRAIN: begin
				if (cur.out_valid && ins_ready && cur.out_last) begin
					nxt.st = ins_ctrl_pkg::ST_IDLE;
					nxt.arm = 1'b0;
					nxt.done = 1'b1;
				end
			end
			ins_ctrl_pkg::ST_FILL: begin
				ram_we = 1'b1;
				ram_wdata = ins_ctrl_pkg::FILL_WORD;
				nxt.wr_idx = cur.wr_idx + 1'b1;
				if (cur.wr_idx == IW'(DEPTH - 1)) begin
					nxt.st = ins_ctrl_pkg::ST_IDLE;
				end
			end
			default: begin
				nxt.st = ins_ctrl_pkg::ST_IDLE;
			end
		endcase

		// control register write; the hardware clear beats a software set
		if (wr_csr0) begin
			nxt.buf_sel = reg_wdata[ins_ctrl_pkg::BIT_BUF_SEL_LO +: ins_ctrl_pkg::BUF_SEL_W];
			nxt.len = reg_wdata[ins_ctrl_pkg::BIT_LEN_LO +: IW];
			if (!cur.arm && cur.st == ins_ctrl_pkg::ST_IDLE) begin
				if (reg_wdata[ins_ctrl_pkg::BIT_WR_CLEAR]) begin
					nxt.wr_idx = ins_ctrl_pkg::RST_IDX;
				end
				if (reg_wdata[ins_ctrl_pkg::BIT_RD_CLEAR]) begin
					nxt.rd_idx = ins_ctrl_pkg::RST_IDX;
				end
				if (reg_wdata[ins_ctrl_pkg::BIT_FILL] && !reg_wdata[ins_ctrl_pkg::BIT_ARM]) begin
					nxt.st = ins_ctrl_pkg::ST_FILL;
				end
			end
			if (reg_wdata[ins_ctrl_pkg::BIT_ARM]) begin
				if (!cur.arm) begin
					nxt.st = ins_ctrl_pkg::ST_IDLE; // arming stops a running fill
					nxt.arm = 1'b1;
					nxt.wr_idx = ins_ctrl_pkg::RST_IDX;
					nxt.rd_idx = ins_ctrl_pkg::RST_IDX;
					nxt.done = 1'b0;
				end
			end else if (cur.st == ins_ctrl_pkg::ST_IDLE) begin
				nxt.arm = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur.st <= ins_ctrl_pkg::ST_IDLE;
			cur.arm <= 1'b0;
			cur.wr_idx <= ins_ctrl_pkg::RST_IDX;
			cur.rd_idx <= ins_ctrl_pkg::RST_IDX;
			cur.buf_sel <= ins_ctrl_pkg::RST_BUF_SEL;
			cur.len <= ins_ctrl_pkg::RST_IDX;
			cur.gap_thr <= ins_ctrl_pkg::RST_GAP;
			cur.rdata <= 32'h00000000;
			cur.out_valid <= 1'b0;
			cur.out_data <= 32'h00000000;
			cur.out_last <= 1'b0;
			cur.out_sel <= ins_ctrl_pkg::RST_BUF_SEL;
			cur.done <= 1'b0;
		end else begin
			cur <= nxt;
		end
	end

	assign reg_rdata = cur.rdata;
	assign ins_valid = cur.out_valid;
	assign ins_data = cur.out_data;
	assign ins_last = cur.out_last;
	assign ins_buffer_select = cur.out_sel;
	assign ins_done = cur.done;
	assign ins_armed = cur.arm;
endmodule // ts_packet_insertion_ctrl
`default_nettype wire

// ===== ins_ctrl_assertions.sv
// port-level checks for the insertion controller
`timescale 1ns/1ns
`default_nettype none
module ins_ctrl_assertions (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic reg_cs,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic [15:0] ts_gap_time,
	input wire logic ins_valid,
	input wire logic ins_ready,
	input wire logic [31:0] ins_data,
	input wire logic ins_last,
	input wire logic [2:0] ins_buffer_select,
	input wire logic ins_done,
	input wire logic ins_armed
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	word_hold_a: assert property (ins_valid && !ins_ready |=>
		ins_valid && $stable(ins_data) && $stable(ins_last)) else $error("stalled word changed");
	done_disarm_a: assert property (ins_done |-> !ins_armed && $past(ins_armed))
		else $error("done without disarm");
	valid_armed_a: assert property (ins_valid |-> ins_armed)
		else $error("word while not armed");
	last_done_a: assert property (ins_valid && ins_ready && ins_last |=> ins_done)
		else $error("no done after last word");
	arm_set_a: assert property (reg_cs && reg_wr && reg_addr == 8'hA8 && reg_wdata[6]
		|=> ins_armed) else $error("arm write ignored");
	csr1_zero_a: assert property (reg_cs && reg_rd && reg_addr == 8'hAC
		|=> reg_rdata[31:16] == 16'h0000) else $error("gap register upper bits set");
	csr0_zero_a: assert property (reg_cs && reg_rd && reg_addr == 8'hA8
		|=> (reg_rdata & 32'hC0C0F880) == 32'h00000000) else $error("control zero bits set");
	select_hold_a: assert property (ins_valid && $past(ins_valid)
		|-> $stable(ins_buffer_select)) else $error("buffer select moved");
	cover property (ins_done);
	cover property (ins_valid && !ins_ready);
	cover property (ins_armed && ts_gap_time >= 16'h09CA);
endmodule // ins_ctrl_assertions
`default_nettype wire

// ===== ins_sink.sv
// stream consumer model that collects inserted words and can stall
`timescale 1ns/1ns
`default_nettype none
module ins_sink (
	input wire logic clk,
	input wire logic stall,
	input wire logic valid,
	input wire logic [31:0] data,
	input wire logic last,
	output logic ready
);
	logic [31:0] got [0:7];
	int n = 0;
	int last_at = -1;
	assign ready = !stall;
	always @(posedge clk) begin
		if (valid && ready) begin
			got[n[2:0]] <= data;
			n <= n + 1;
			if (last) begin
				last_at <= n;
			end
		end
	end
endmodule // ins_sink
`default_nettype wire

// ===== ts_packet_insertion_ctrl_test.sv
// self-checking bench for the insertion controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module ts_packet_insertion_ctrl_test;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic reg_cs = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h00000000;
	logic [15:0] ts_gap_time = 16'h0000;
	logic stall = 1'b1;
	logic [31:0] reg_rdata, ins_data, rv;
	logic ins_valid, ins_ready, ins_last, ins_done, ins_armed;
	logic [2:0] ins_buffer_select;
	int failures = 0;
	int check_count = 0;
	ts_packet_insertion_ctrl uut (.clk(clk), .arst_n(arst_n), .reg_cs(reg_cs), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.ts_gap_time(ts_gap_time), .ins_valid(ins_valid), .ins_ready(ins_ready),
		.ins_data(ins_data), .ins_last(ins_last), .ins_buffer_select(ins_buffer_select),
		.ins_done(ins_done), .ins_armed(ins_armed));
	ins_sink sink (.clk(clk), .stall(stall), .valid(ins_valid), .data(ins_data),
		.last(ins_last), .ready(ins_ready));
	initial begin
		forever #20 clk = ~clk;
	end
	function automatic logic [31:0] word(input int i);
		return {16'hC0DE, i[15:0]};
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk);
		{reg_cs, reg_wr, reg_addr, reg_wdata} = {2'b11, a, d};
		@(negedge clk);
		{reg_cs, reg_wr} = 2'b00;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		@(negedge clk);
		{reg_cs, reg_rd, reg_addr} = {2'b11, a};
		@(negedge clk);
		{reg_cs, reg_rd} = 2'b00;
		rv = reg_rdata;
		`CHK(rv, e)
	endtask
	task automatic end_of_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge clk);
		arst_n = 1'b1;
		repeat (3) @(negedge clk);
		rc(8'hA8, 32'h00000000);
		rc(8'hAC, 32'h00000000);
		wr(8'hB0, 32'hFFFFFFFF);
		rc(8'hB0, 32'h00000000);
		wr(8'hAC, 32'hFFFFFFFF);
		rc(8'hAC, 32'h0000FFFF);
		wr(8'hAC, 32'h000009CA);
		wr(8'hA8, 32'h8080FD06);
		rc(8'hA8, 32'h00000506);
		$display("register test done");
		for (int i = 0; i < 3; i++) wr(8'hA4, word(i));
		rc(8'hA8, 32'h03000506);
		wr(8'hA8, 32'h40400506);
		rc(8'hA8, 32'h00000506);
		for (int i = 0; i < 3; i++) wr(8'hA4, word(i));
		rc(8'hA4, word(0));
		rc(8'hA8, 32'h03010506);
		wr(8'hA8, 32'h00000586);
		repeat (70) @(negedge clk);
		rc(8'hA8, 32'h00010506);
		wr(8'hA4, word(0));
		$display("ram test done");
		ts_gap_time = 16'h09C9;
		wr(8'hA8, 32'h00000546);
		rc(8'hA8, 32'h00000546);
		wr(8'hA4, 32'h00000000);
		repeat (10) @(negedge clk);
		`CHK(ins_valid, 1'b0)
		ts_gap_time = 16'h09CA;
		repeat (12) @(negedge clk);
		`CHK(ins_valid, 1'b1)
		`CHK(ins_buffer_select, 3'h5)
		stall = 1'b0;
		for (int i = 0; i < 100 && ins_armed !== 1'b0; i++) @(negedge clk);
		if (ins_armed !== 1'b0) failures++;
		`CHK(ins_done, 1'b1)
		`CHK(sink.n, 6)
		`CHK(sink.last_at, 5)
		for (int i = 0; i < 6; i++) `CHK(sink.got[i], i < 3 ? word(i) : 32'hFFFFFFFF)
		rc(8'hA8, 32'h00060506);
		wr(8'hA8, 32'h00000540);
		rc(8'hA8, 32'h00000500);
		`CHK(sink.n, 6)
		ts_gap_time = 16'h0000;
		wr(8'hA8, 32'h00000546);
		wr(8'hA8, 32'h00000506);
		rc(8'hA8, 32'h00000506);
		$display("insertion test done");
		end_of_test();
	end
endmodule // ts_packet_insertion_ctrl_test
bind ts_packet_insertion_ctrl ins_ctrl_assertions chk (.clk(clk), .arst_n(arst_n),
	.reg_cs(reg_cs), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ts_gap_time(ts_gap_time),
	.ins_valid(ins_valid), .ins_ready(ins_ready), .ins_data(ins_data), .ins_last(ins_last),
	.ins_buffer_select(ins_buffer_select), .ins_done(ins_done), .ins_armed(ins_armed));
`default_nettype wire
